// [rtl/ddtc_params.svh]
// Operation
// - Output code register is never written by software, only loaded on transfer.
// - Trigger disabled: hold value reaches output one cycle after the write.
// - Timer or interrupt-line trigger: transfer completes three cycles after trigger.
// - Software trigger: transfer completes two cycles after the trigger write.
// - Each channel picks timer, interrupt line or software as trigger source.
// - Single writes take [7:0], [15:4] or [11:0] per format.
// - Dual left-aligned: channel 1 from [15:4], channel 2 from [31:20].
// - Dual right-aligned: channel 1 from [11:0], channel 2 from [27:16].
// - Dual 8-bit: [15:0], low byte channel 1, high byte channel 2.
// - Output code is 12-bit unsigned, 4095 full scale.
// - Channels run independently; one never disturbs the other.
// - Each channel has its own noise and triangle generator.
// - One dual write updates both channels' holding data.
// - Both triggers off: dual write loads both outputs together next cycle.
// - Same timer or interrupt-line source on both channels transfers both together.
// - Different sources: each channel transfers only on its own trigger.
// - Noise mask setting held separately per channel.
// - Triangle amplitude setting held separately per channel.
// - Source codes 0-5 timers, 6 interrupt line 9, 7 software.
// - Selector n unmasks bits [n:0], amplitude 2^(n+1)-1, capped at 4095.
`ifndef DDTC_PARAMS_SVH
`define DDTC_PARAMS_SVH
`define DDTC_OFS_CTRL      6'h00
`define DDTC_OFS_SWTRG     6'h04
`define DDTC_OFS_H12R1     6'h08
`define DDTC_OFS_H12L1     6'h0c
`define DDTC_OFS_H8R1      6'h10
`define DDTC_OFS_H12R2     6'h14
`define DDTC_OFS_H12L2     6'h18
`define DDTC_OFS_H8R2      6'h1c
`define DDTC_OFS_D12R      6'h20
`define DDTC_OFS_D12L      6'h24
`define DDTC_OFS_D8R       6'h28
`define DDTC_OFS_OUT1      6'h2c
`define DDTC_OFS_OUT2      6'h30
`define DDTC_CTRL_RST      32'h0000_0000
`define DDTC_CTRL_MASK     32'h1fff_1fff
`define DDTC_CH2_SHIFT     16
`define DDTC_TEN_BIT       2
`define DDTC_TSEL_LSB      3
`define DDTC_WAVE_LSB      6
`define DDTC_MAMP_LSB      8
`define DDTC_SRC_EXTI      3'h6
`define DDTC_SRC_SW        3'h7
`define DDTC_HW_DELAY      2'h2
`define DDTC_LFSR_SEED     12'haaa
`define DDTC_FULL_SCALE    12'hfff
`endif

// [rtl/ddtc_pkg.sv]
`default_nettype none
package ddtc_pkg;
    typedef struct packed {
        logic [5:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ddtc_bus_req_t;
    typedef enum logic [1:0] {
        DDTC_WAVE_NONE  = 2'b00,
        DDTC_WAVE_NOISE = 2'b01,
        DDTC_WAVE_TRI   = 2'b10,
        DDTC_WAVE_TRI2  = 2'b11
    } ddtc_wave_t;
endpackage
`default_nettype wire

// [rtl/ddtc_top.sv]
`include "ddtc_params.svh"
`default_nettype none
module ddtc_top (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   reset_n,
    // register port
    input  wire ddtc_pkg::ddtc_bus_req_t bus_req,
    output logic [31:0]                 rdata,
    // trigger sources, asynchronous pins
    input  wire logic [5:0]             timer_trig,
    input  wire logic                   exti_line9,
    // codes to the analog stage
    output logic [11:0]                 ch1_code,
    output logic [11:0]                 ch2_code
);
    import ddtc_pkg::*;

    logic [31:0]      ctrl_r;
    logic [1:0]       swtrg_r;
    logic [11:0]      hold_r   [2];
    logic [11:0]      out_r    [2];
    logic [11:0]      lfsr_r   [2];
    logic [11:0]      tri_r    [2];
    logic [1:0]       tri_dn_r;
    logic [1:0]       sw_load_r;
    logic [1:0]       auto_r;
    logic [1:0]       hw_pend_r;
    logic [1:0]       hw_cnt_r [2];
    logic [6:0]       ext_s1_r;
    logic [6:0]       ext_s2_r;
    logic [6:0]       ext_s3_r;
    logic [1:0]       hold_wr;
    logic [11:0]      hold_nxt [2];
    logic [1:0]       xfer;
    logic [1:0]       hw_fire;

    function automatic logic [11:0] ddtc_mask(input logic [3:0] n);
        // selector n opens bits [n:0], saturating at twelve bits
        ddtc_mask = (n >= 4'hb) ? `DDTC_FULL_SCALE : 12'((13'h2 << n) - 13'h1);
    endfunction

    function automatic logic [11:0] ddtc_sat(input logic [11:0] a, input logic [11:0] b);
        logic [12:0] s;
        s = {1'b0, a} + {1'b0, b};
        ddtc_sat = s[12] ? `DDTC_FULL_SCALE : s[11:0];
    endfunction

    // trigger pins: two flops, third for edge detect
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_s1_r <= 7'h00;
            ext_s2_r <= 7'h00;
            ext_s3_r <= 7'h00;
        end else begin
            ext_s1_r <= {exti_line9, timer_trig};
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    wire logic [31:0] wd = bus_req.wdata;
    wire logic        wr = bus_req.wr;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= `DDTC_CTRL_RST;
        end else if (wr && bus_req.addr == `DDTC_OFS_CTRL) begin
            ctrl_r <= wd & `DDTC_CTRL_MASK;
        end
    end

    // holding data decode per write format
    always_comb begin
        hold_wr     = 2'b00;
        hold_nxt[0] = hold_r[0];
        hold_nxt[1] = hold_r[1];
        if (wr) begin
            unique case (bus_req.addr)
                `DDTC_OFS_H12R1: begin
                    hold_wr     = 2'b01;
                    hold_nxt[0] = wd[11:0];
                end
                `DDTC_OFS_H12L1: begin
                    hold_wr     = 2'b01;
                    hold_nxt[0] = wd[15:4];
                end
                `DDTC_OFS_H8R1: begin
                    hold_wr     = 2'b01;
                    hold_nxt[0] = {wd[7:0], 4'h0};
                end
                `DDTC_OFS_H12R2: begin
                    hold_wr     = 2'b10;
                    hold_nxt[1] = wd[11:0];
                end
                `DDTC_OFS_H12L2: begin
                    hold_wr     = 2'b10;
                    hold_nxt[1] = wd[15:4];
                end
                `DDTC_OFS_H8R2: begin
                    hold_wr     = 2'b10;
                    hold_nxt[1] = {wd[7:0], 4'h0};
                end
                `DDTC_OFS_D12R: begin
                    hold_wr = 2'b11;
                    hold_nxt[0] = wd[11:0];
                    hold_nxt[1] = wd[27:16];
                end
                `DDTC_OFS_D12L: begin
                    hold_wr = 2'b11;
                    hold_nxt[0] = wd[15:4];
                    hold_nxt[1] = wd[31:20];
                end
                `DDTC_OFS_D8R: begin
                    hold_wr = 2'b11;
                    hold_nxt[0] = {wd[7:0], 4'h0};
                    hold_nxt[1] = {wd[15:8], 4'h0};
                end
                default: begin
                    hold_wr = 2'b00;
                end
            endcase
        end
    end

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_ch
            localparam int SH = c * `DDTC_CH2_SHIFT;
            wire logic       ten  = ctrl_r[SH + `DDTC_TEN_BIT];
            wire logic [2:0] tsel = ctrl_r[SH + `DDTC_TSEL_LSB +: 3];
            wire ddtc_wave_t wave = ddtc_wave_t'(ctrl_r[SH + `DDTC_WAVE_LSB +: 2]);
            wire logic [3:0] mamp = ctrl_r[SH + `DDTC_MAMP_LSB +: 4];
            wire logic [11:0] amp = ddtc_mask(mamp);
            logic             edge_hit;

            always_comb begin
                edge_hit = 1'b0;
                if (tsel == `DDTC_SRC_EXTI) begin
                    edge_hit = ext_s2_r[6] & ~ext_s3_r[6];
                end else if (tsel != `DDTC_SRC_SW) begin
                    edge_hit = ext_s2_r[tsel] & ~ext_s3_r[tsel];
                end
            end
            assign hw_fire[c] = ten & edge_hit;

            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    hold_r[c] <= 12'h000;
                end else if (hold_wr[c]) begin
                    hold_r[c] <= hold_nxt[c];
                end
            end

            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    auto_r[c] <= 1'b0;
                end else begin
                    auto_r[c] <= hold_wr[c] & ~ten;
                end
            end

            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    hw_pend_r[c] <= 1'b0;
                    hw_cnt_r[c]  <= 2'h0;
                end else if (hw_fire[c]) begin
                    hw_pend_r[c] <= 1'b1;
                    hw_cnt_r[c]  <= 2'h0;
                end else if (hw_pend_r[c]) begin
                    hw_cnt_r[c]  <= hw_cnt_r[c] + 2'h1;
                    hw_pend_r[c] <= (hw_cnt_r[c] != `DDTC_HW_DELAY);
                end
            end

            // software trigger load one cycle on
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    sw_load_r[c] <= 1'b0;
                end else begin
                    // one pulse per request, bit clears on the transfer edge
                    sw_load_r[c] <= swtrg_r[c] & ~sw_load_r[c] & ten
                                  & (tsel == `DDTC_SRC_SW);
                end
            end

            // each channel fires on its own source only
            assign xfer[c] = auto_r[c] | sw_load_r[c]
                           | (hw_pend_r[c] & (hw_cnt_r[c] == `DDTC_HW_DELAY));

            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    lfsr_r[c] <= `DDTC_LFSR_SEED;
                end else if (xfer[c] && wave == DDTC_WAVE_NOISE) begin
                    lfsr_r[c] <= {lfsr_r[c][10:0],
                                  lfsr_r[c][11] ^ lfsr_r[c][5] ^ lfsr_r[c][3] ^ lfsr_r[c][0]};
                end
            end

            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    tri_r[c]    <= 12'h000;
                    tri_dn_r[c] <= 1'b0;
                end else if (xfer[c] && wave[1]) begin
                    if (!tri_dn_r[c]) begin
                        if (tri_r[c] >= amp) begin
                            tri_dn_r[c] <= 1'b1;
                            tri_r[c]    <= tri_r[c] - 12'h001;
                        end else begin
                            tri_r[c] <= tri_r[c] + 12'h001;
                        end
                    end else if (tri_r[c] == 12'h000) begin
                        tri_dn_r[c] <= 1'b0;
                        tri_r[c]    <= 12'h001;
                    end else begin
                        tri_r[c] <= tri_r[c] - 12'h001;
                    end
                end
            end

            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    out_r[c] <= 12'h000;
                end else if (xfer[c]) begin
                    unique case (wave)
                        DDTC_WAVE_NONE:  out_r[c] <= hold_r[c];
                        DDTC_WAVE_NOISE: out_r[c] <= ddtc_sat(hold_r[c], lfsr_r[c] & amp);
                        DDTC_WAVE_TRI,
                        DDTC_WAVE_TRI2:  out_r[c] <= ddtc_sat(hold_r[c], tri_r[c]);
                    endcase
                end
            end
        end
    endgenerate

    // software trigger self-clear, write sets win
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            swtrg_r <= 2'b00;
        end else if (wr && bus_req.addr == `DDTC_OFS_SWTRG) begin
            swtrg_r <= wd[1:0];
        end else begin
            swtrg_r <= swtrg_r & ~sw_load_r;
        end
    end

    // 12-bit codes registered from output registers, one cycle behind
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ch1_code <= 12'h000;
            ch2_code <= 12'h000;
        end else begin
            ch1_code <= out_r[0];
            ch2_code <= out_r[1];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 32'h0000_0000;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                `DDTC_OFS_CTRL:  rdata <= ctrl_r;
                `DDTC_OFS_SWTRG: rdata <= {30'h0, swtrg_r};
                `DDTC_OFS_H12R1: rdata <= {20'h0, hold_r[0]};
                `DDTC_OFS_H12L1: rdata <= {16'h0, hold_r[0], 4'h0};
                `DDTC_OFS_H8R1:  rdata <= {24'h0, hold_r[0][11:4]};
                `DDTC_OFS_H12R2: rdata <= {20'h0, hold_r[1]};
                `DDTC_OFS_H12L2: rdata <= {16'h0, hold_r[1], 4'h0};
                `DDTC_OFS_H8R2:  rdata <= {24'h0, hold_r[1][11:4]};
                `DDTC_OFS_D12R:  rdata <= {4'h0, hold_r[1], 4'h0, hold_r[0]};
                `DDTC_OFS_D12L:  rdata <= {hold_r[1], 4'h0, hold_r[0], 4'h0};
                `DDTC_OFS_D8R:   rdata <= {16'h0, hold_r[1][11:4], hold_r[0][11:4]};
                `DDTC_OFS_OUT1:  rdata <= {20'h0, out_r[0]};
                `DDTC_OFS_OUT2:  rdata <= {20'h0, out_r[1]};
                default:         rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    // write with trigger off loads next cycle
    AST_AUTO_LOAD: assert property (@(posedge sys_clk) disable iff (!reset_n)
        hold_wr[0] && !ctrl_r[`DDTC_TEN_BIT] && ctrl_r[7:6] == 2'b00
        |=> ##1 out_r[0] == $past(hold_nxt[0], 2))
        else $error("channel 1 auto load missed");

    sequence s_hw_edge;
        hw_fire[0] && ctrl_r[7:6] == 2'b00;
    endsequence
    AST_HW_DELAY: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_hw_edge ##1 !hw_fire[0] [*2] |=> xfer[0])
        else $error("hardware trigger transfer not after three cycles");

    AST_SW_LOAD: assert property (@(posedge sys_clk) disable iff (!reset_n)
        swtrg_r[0] && !sw_load_r[0] && ctrl_r[`DDTC_TEN_BIT] && ctrl_r[5:3] == `DDTC_SRC_SW
        |=> xfer[0])
        else $error("software trigger transfer late");

    AST_NO_SPURIOUS: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !xfer[1] |=> $stable(out_r[1]))
        else $error("output changed without transfer");

    AST_SW_CLEAR: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sw_load_r[1] && !(wr && bus_req.addr == `DDTC_OFS_SWTRG) |=> !swtrg_r[1])
        else $error("software trigger bit not cleared");

    AST_DUAL_SYNC: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr && bus_req.addr == `DDTC_OFS_D12R && !ctrl_r[2] && !ctrl_r[18]
        |=> xfer[0] && xfer[1])
        else $error("dual write did not load both channels");

    AST_ISOLATE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        hold_wr == 2'b01 |=> $stable(hold_r[1]))
        else $error("channel 1 write disturbed channel 2");

    AST_CODE_OUT: assert property (@(posedge sys_clk) disable iff (!reset_n)
        1'b1 |=> ch2_code == $past(out_r[1]))
        else $error("channel 2 code not following output register");

    AST_AUTO_LOAD2: assert property (@(posedge sys_clk) disable iff (!reset_n)
        hold_wr[1] && !ctrl_r[18] && ctrl_r[23:22] == 2'b00
        |=> ##1 out_r[1] == $past(hold_nxt[1], 2))
        else $error("channel 2 auto load missed");

    sequence s_hw_edge2;
        hw_fire[1] && ctrl_r[23:22] == 2'b00;
    endsequence
    AST_HW_DELAY2: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_hw_edge2 ##1 !hw_fire[1] [*2] |=> xfer[1])
        else $error("channel 2 hardware transfer not after three cycles");

    AST_SW_LOAD2: assert property (@(posedge sys_clk) disable iff (!reset_n)
        swtrg_r[1] && !sw_load_r[1] && ctrl_r[18] && ctrl_r[21:19] == `DDTC_SRC_SW
        |=> xfer[1])
        else $error("channel 2 software trigger transfer late");

    AST_NO_SPURIOUS1: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !xfer[0] |=> $stable(out_r[0]))
        else $error("channel 1 output changed without transfer");

    AST_SW_CLEAR1: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sw_load_r[0] && !(wr && bus_req.addr == `DDTC_OFS_SWTRG) |=> !swtrg_r[0])
        else $error("channel 1 software trigger bit not cleared");

    AST_ISOLATE2: assert property (@(posedge sys_clk) disable iff (!reset_n)
        hold_wr == 2'b10 |=> $stable(hold_r[0]))
        else $error("channel 2 write disturbed channel 1");

    AST_CODE_OUT1: assert property (@(posedge sys_clk) disable iff (!reset_n)
        1'b1 |=> ch1_code == $past(out_r[0]))
        else $error("channel 1 code not following output register");

    AST_SAME_SRC: assert property (@(posedge sys_clk) disable iff (!reset_n)
        hw_fire[0] && ctrl_r[18] && ctrl_r[5:3] == ctrl_r[21:19] |-> hw_fire[1])
        else $error("shared trigger source did not fire both channels");

    AST_SW_NO_HW: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ctrl_r[5:3] == `DDTC_SRC_SW |-> !hw_fire[0])
        else $error("pin edge fired a software triggered channel");

    AST_MASK_CAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ctrl_r[11:8] >= 4'hb |-> g_ch[0].amp == `DDTC_FULL_SCALE)
        else $error("mask selector above eleven not capped");

    AST_TRI_UP: assert property (@(posedge sys_clk) disable iff (!reset_n)
        xfer[0] && ctrl_r[7] && !tri_dn_r[0] && tri_r[0] < g_ch[0].amp
        |=> tri_r[0] == $past(tri_r[0]) + 12'h001)
        else $error("triangle counter did not step up");

    AST_LFSR_LIVE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        lfsr_r[0] != 12'h000 && lfsr_r[1] != 12'h000)
        else $error("noise register locked at zero");

endmodule
`default_nettype wire

// [verification/ddtc_trig_model.sv]
`default_nettype none
module ddtc_trig_model (
    // clock
    input  wire logic       sys_clk,
    // trigger pins into the block
    output var logic [5:0]  timer_trig,
    output var logic        exti_line9
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        timer_trig = 6'h00;
        exti_line9 = 1'b0;
    end

    task automatic drive(input logic [2:0] src, input logic lvl);
        @(posedge sys_clk);
        if (src == 3'h6) begin
            exti_line9 <= lvl;
        end else begin
            timer_trig[src] <= lvl;
        end
    endtask
endmodule
`default_nettype wire

// [verification/ddtc_top_tb.sv]
`include "ddtc_params.svh"
`default_nettype none
module ddtc_top_tb;
    import ddtc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic          sys_clk;
    logic          reset_n;
    ddtc_bus_req_t bus_req;
    logic [31:0]   rdata;
    logic [5:0]    timer_trig;
    logic          exti_line9;
    logic [11:0]   ch1_code;
    logic [11:0]   ch2_code;
    int            n_mismatch = 0;
    int            checks_done = 0;
    int            cyc = 0;
    logic [31:0]   wdat_tab [3] = '{32'hffff_ffff, 32'hffff_abcf, 32'hffff_ff5a};
    logic [11:0]   exp_tab  [3] = '{12'hfff, 12'habc, 12'h5a0};
    logic [31:0]   dw_tab   [3] = '{32'hf456_f789, 32'h123f_456f, 32'hffff_3cc3};
    logic [11:0]   d1_tab   [3] = '{12'h789, 12'h456, 12'hc30};
    logic [11:0]   d2_tab   [3] = '{12'h456, 12'h123, 12'h3c0};

    ddtc_top dut_u (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .bus_req    (bus_req),
        .rdata      (rdata),
        .timer_trig (timer_trig),
        .exti_line9 (exti_line9),
        .ch1_code   (ch1_code),
        .ch2_code   (ch2_code)
    );

    ddtc_trig_model model_u (
        .sys_clk    (sys_clk),
        .timer_trig (timer_trig),
        .exti_line9 (exti_line9)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // codes keep old values until edge n after the write, new ones at edge n
    task automatic expect_codes(input int n, input logic [11:0] o1, o2, e1, e2);
        repeat (n - 1) @(posedge sys_clk);
        #1;
        check("codes early", {8'h00, ch1_code, ch2_code}, {8'h00, o1, o2});
        @(posedge sys_clk);
        #1;
        check("codes", {8'h00, ch1_code, ch2_code}, {8'h00, e1, e2});
    endtask

    // pin edge to code change, both channels watched together
    task automatic hw_fire(input logic [2:0] src, input logic [11:0] o1, o2, e1, e2);
        int k;
        k = 0;
        model_u.drive(src, 1'b1);
        while ({ch1_code, ch2_code} === {o1, o2} && k < 12) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        // two sync flops, edge detect, three cycles, code register
        check("hw delay", 32'(k), 32'h7);
        check("hw codes", {8'h00, ch1_code, ch2_code}, {8'h00, e1, e2});
        model_u.drive(src, 1'b0);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    initial begin
        logic [31:0] d;
        logic [11:0] c1, c2, v;
        reset_n = 1'b0;
        bus_req = '0;
        c1 = 12'h000;
        c2 = 12'h000;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(`DDTC_OFS_CTRL, d);
        check("ctrl reset", d, `DDTC_CTRL_RST);
        rd(`DDTC_OFS_OUT2, d);
        check("out2 reset", d, 32'h0);
        for (int ch = 0; ch < 2; ch++) begin
            for (int f = 0; f < 3; f++) begin
                v = exp_tab[f];
                wr(6'(8 + 12 * ch + 4 * f), wdat_tab[f]);
                expect_codes(2, c1, c2, ch ? c1 : v, ch ? v : c2);
                if (ch == 1) c2 = v;
                else c1 = v;
                rd(6'(8'h2c + 4 * ch), d);
                check("output reg", d, {20'h0, v});
            end
        end
        wr(`DDTC_OFS_OUT1, 32'h0000_0123);
        expect_codes(2, c1, c2, c1, c2);
        rd(`DDTC_OFS_OUT1, d);
        check("out1 kept", d, {20'h0, c1});
        rd(6'h3c, d);
        check("unmapped", d, 32'h0);
        for (int i = 0; i < 3; i++) begin
            wr(6'(8'h20 + 4 * i), dw_tab[i]);
            expect_codes(2, c1, c2, d1_tab[i], d2_tab[i]);
            c1 = d1_tab[i];
            c2 = d2_tab[i];
        end
        // ch1 software source, ch2 interrupt line
        wr(`DDTC_OFS_CTRL, 32'h0034_003c);
        rd(`DDTC_OFS_CTRL, d);
        check("ctrl", d, 32'h0034_003c);
        wr(`DDTC_OFS_H12R1, 32'h321);
        wr(`DDTC_OFS_H12R2, 32'h654);
        expect_codes(4, c1, c2, c1, c2);
        wr(`DDTC_OFS_SWTRG, 32'h1);
        expect_codes(3, c1, c2, 12'h321, c2);
        c1 = 12'h321;
        rd(`DDTC_OFS_SWTRG, d);
        check("swtrg clear", d, 32'h0);
        hw_fire(3'h6, c1, c2, c1, 12'h654);
        c2 = 12'h654;
        for (int s = 0; s < 6; s++) begin
            wr(`DDTC_OFS_CTRL, {10'h0, 3'(s), 3'h4, 10'h0, 3'(s), 3'h4});
            v = 12'(s * 100 + 7);
            wr(`DDTC_OFS_D12R, {4'h0, ~v, 4'h0, v});
            model_u.drive(3'((s + 1) % 6), 1'b1);
            expect_codes(10, c1, c2, c1, c2);
            model_u.drive(3'((s + 1) % 6), 1'b0);
            hw_fire(3'(s), c1, c2, v, ~v);
            c1 = v;
            c2 = ~v;
        end
        // ch1 triangle amplitude 1, ch2 noise full mask
        wr(`DDTC_OFS_CTRL, 32'h0b7c_00bc);
        wr(`DDTC_OFS_H12R1, 32'h100);
        wr(`DDTC_OFS_H12R2, 32'hfff);
        for (int i = 0; i < 4; i++) begin
            wr(`DDTC_OFS_SWTRG, 32'h3);
            repeat (3) @(posedge sys_clk);
            #1;
            check("noise sat", {20'h0, ch2_code}, 32'hfff);
            check("tri step", {20'h0, ch1_code}, (i % 2 == 1) ? 32'h101 : 32'h100);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
